// ===== verif/bioss_bank_properties.sv
// Purpose: Port assertions for the bank
// Assumes: Writes land one edge after being taken
// Notes:   Window outputs lag by one more edge
`timescale 1ns/1ps
module bioss_bank_chk (
  input wire logic                   clk,
  input wire logic                   rstn,
  input wire logic                   cfg_wr,
  input wire logic                   cfg_rd,
  input wire logic [7:0]             cfg_addr,
  input wire bioss_pkg::bioss_byte_t cfg_wdata,
  input wire bioss_pkg::bioss_byte_t cfg_rdata,
  input wire logic                   serr_seen,
  input wire bioss_pkg::bioss_addr_t io_addr,
  input wire logic                   io_forward_hit,
  input wire bioss_pkg::bioss_addr_t io_window_bottom_addr,
  input wire bioss_pkg::bioss_addr_t io_window_top_addr,
  input wire bioss_pkg::bioss_byte_t secondary_latency_count
);
  import bioss_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  lat_write_a: assert property (cfg_wr && cfg_addr == 8'h1b |=>
    secondary_latency_count == $past(cfg_wdata)) else $error("latency write lost");
  bot_low_a: assert property (io_window_bottom_addr[11:0] == 12'h000) else $error("bottom low bits");
  top_low_a: assert property (io_window_top_addr[11:0] == 12'hfff) else $error("top low bits");
  bot_upper_a: assert property (cfg_wr && cfg_addr == 8'h30 |=> ##1
    io_window_bottom_addr[23:16] == $past(cfg_wdata, 2)) else $error("bottom upper");
  top_upper_a: assert property (cfg_wr && cfg_addr == 8'h33 |=> ##1
    io_window_top_addr[31:24] == $past(cfg_wdata, 2)) else $error("top upper");
  type_code_a: assert property (cfg_rd && cfg_addr[7:1] == 7'h0e |=>
    cfg_rdata[3:0] == 4'h1) else $error("type code");
  window_hit_a: assert property (io_forward_hit == (io_addr >= io_window_bottom_addr &&
    io_addr <= io_window_top_addr)) else $error("hit wrong");
  serr_set_a: assert property (serr_seen ##1 !cfg_wr ##1 cfg_rd && cfg_addr == 8'h1f |=>
    cfg_rdata[6]) else $error("serr flag");
  stat_fixed_a: assert property (cfg_rd && cfg_addr == 8'h1e |=>
    cfg_rdata == 8'h80) else $error("status low byte");
endmodule : bioss_bank_chk
bind bioss_bank bioss_bank_chk bioss_bank_chk_inst (.clk, .rstn, .cfg_wr, .cfg_rd, .cfg_addr,
  .cfg_wdata, .cfg_rdata, .serr_seen, .io_addr, .io_forward_hit, .io_window_bottom_addr,
  .io_window_top_addr, .secondary_latency_count);

// ===== verif/bioss_bank_tb.sv
// Purpose: Bench for the I/O window and secondary status bank
// Assumes: Inputs change on the falling edge
// Notes:   Agent model supplies error pulses
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; $display("MISMATCH %0t %h exp %h", $time, a, e); end end
module bioss_bank_tb;
  import bioss_pkg::*;
  logic        clk, rstn, cfg_wr, cfg_rd, pre, hit;
  logic [7:0]  cfg_addr;
  logic [8:0]  ev;
  bioss_byte_t cfg_wdata, cfg_rdata, lat;
  bioss_addr_t io_addr, bot, top;
  int          n_fail, check_count, cyc;
  logic [7:0]  hi_exp [9] = '{8'h82, 8'h82, 8'h82, 8'h42, 8'h22, 8'h12, 8'h0a, 8'h03, 8'h03};
  bioss_addr_t probe [4] = '{32'h1234_a000, 32'h1234_9fff, 32'h5678_3fff, 32'h5678_4000};
  bioss_sec_agent bioss_sec_agent_inst (.clk, .ev);
  bioss_bank bioss_bank_inst (.clk, .rstn, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_rdata,
    .parity_response_enable(pre), .addr_attr_err_as_target(ev[0]), .data_err_as_write_target(ev[1]),
    .data_err_as_read_master(ev[2]), .serr_seen(ev[3]), .master_abort_seen(ev[4]),
    .target_abort_received(ev[5]), .target_abort_signalled(ev[6]), .perr_driven_on_read(ev[7]),
    .perr_seen_on_write(ev[8]), .io_addr, .io_forward_hit(hit), .io_window_bottom_addr(bot),
    .io_window_top_addr(top), .secondary_latency_count(lat));
  task automatic wr(input logic [7:0] a, input bioss_byte_t d);
    @(negedge clk) {cfg_wr, cfg_addr, cfg_wdata} = {1'b1, a, d};
    @(negedge clk) cfg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input bioss_byte_t e);
    @(negedge clk) {cfg_rd, cfg_addr} = {1'b1, a};
    @(negedge clk) cfg_rd = 1'b0;
    `CHK(cfg_rdata, e)
  endtask : rd
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Generous ceiling: the sequence needs well under 400 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    {rstn, cfg_wr, cfg_rd, pre, cfg_addr, cfg_wdata, io_addr} = '0;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    `CHK(top, 32'h0000_0fff)
    rd(8'h1b, 8'h00);
    rd(8'h1c, 8'h01);
    rd(8'h1d, 8'h01);
    rd(8'h1e, 8'h80);
    rd(8'h1f, 8'h02);
    wr(8'h1b, 8'ha5);
    rd(8'h1b, 8'ha5);
    `CHK(lat, 8'ha5)
    wr(8'h1c, 8'ha5);
    rd(8'h1c, 8'ha1);
    wr(8'h1d, 8'h3f);
    rd(8'h1d, 8'h31);
    wr(8'h30, 8'h34);
    wr(8'h31, 8'h12);
    wr(8'h32, 8'h78);
    wr(8'h33, 8'h56);
    rd(8'h30, 8'h34);
    rd(8'h33, 8'h56);
    wr(8'h1e, 8'hff);
    rd(8'h1e, 8'h80);
    `CHK(bot, 32'h1234_a000)
    `CHK(top, 32'h5678_3fff)
    wr(8'h20, 8'hff);
    rd(8'h20, 8'h00);
    foreach (probe[i]) begin
      @(negedge clk) io_addr = probe[i];
      #1 `CHK(hit, 1'(i % 2 == 0))
    end
    for (int k = 0; k < 9; k++) begin
      pre = (k > 2);
      bioss_sec_agent_inst.fire(k);
      rd(8'h1f, hi_exp[k]);
      wr(8'h1f, 8'h00);
      rd(8'h1f, hi_exp[k]);
      wr(8'h1f, hi_exp[k]);
      rd(8'h1f, 8'h02);
      if (k > 6) begin
        pre = 1'b0;
        bioss_sec_agent_inst.fire(k);
        rd(8'h1f, 8'h02);
      end
    end
    // Mid-run reset with a flag set and the timer loaded
    bioss_sec_agent_inst.fire(3);
    @(negedge clk) rstn = 1'b0;
    @(negedge clk) rstn = 1'b1;
    `CHK(lat, 8'h00)
    rd(8'h1f, 8'h02);
    `CHK(bot, 32'h0000_0000)
    `CHK(top, 32'h0000_0fff)
    report_and_stop();
  end
endmodule : bioss_bank_tb

// ===== verif/bioss_sec_agent.sv
// Purpose: Secondary bus agent raising error event pulses
// Assumes: Pulses launched at the falling edge
// Notes:   One event per call
`timescale 1ns/1ps
module bioss_sec_agent (
  input  wire logic       clk,
  output logic      [8:0] ev
);
  initial ev = 9'h000;
  task automatic fire(input int k);
    @(negedge clk) ev[k] = 1'b1;
    @(negedge clk) ev = 9'h000;
  endtask : fire
endmodule : bioss_sec_agent

// ===== verilog/bioss_bank.sv
// Purpose: Secondary latency timer, I/O window and secondary status registers of a bridge
// Assumes: Byte-wide configuration access, one access per cycle, read data registered
// Notes:   Error events are one-cycle pulses from the secondary bus logic
// Notes on behaviour
// [R1] Secondary latency timer is an 8-bit read/write register cleared to zero at reset.
// [R2] Bottom nibble bits 7:4 give I/O address 15:12 of the lowest address, lower 12 bits zero.
// [R3] Top nibble bits 7:4 give I/O address 15:12 of the highest address, lower 12 bits ones.
// [R4] Bottom address bits 31:16 come from a 16-bit register at offset 30h.
// [R5] Top address bits 31:16 come from a 16-bit register at offset 32h.
// [R6] Bits 3:0 of both window registers read 1h and ignore writes.
// [R7] The bottom to top range decides whether an I/O transaction is forwarded.
// [R8] Bit 15 sets on any of three uncorrectable error cases on the secondary side.
// [R9] Bit 15 sets regardless of the parity response enable.
// [R10] Bit 14 sets whenever SERR is seen on the secondary bus.
// [R11] Bit 13 sets on master abort, bit 12 on received target abort, bit 11 on signalled target abort.
// [R12] Bit 8 sets as master with parity response enabled on PERR driven on read or seen on write.
// [R13] Bits 10:9 read 01b and bit 7 reads 1 as fixed values.
// [R14] Error bits stay set until software writes one to them; zero writes leave them.
`timescale 1ns/1ps
`include "bioss_regs.svh"
module bioss_bank (
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic                    cfg_wr,
  input  wire logic                    cfg_rd,
  input  wire logic [7:0]              cfg_addr,
  input  wire bioss_pkg::bioss_byte_t  cfg_wdata,
  output bioss_pkg::bioss_byte_t       cfg_rdata,
  input  wire logic                    parity_response_enable,
  input  wire logic                    addr_attr_err_as_target,
  input  wire logic                    data_err_as_write_target,
  input  wire logic                    data_err_as_read_master,
  input  wire logic                    serr_seen,
  input  wire logic                    master_abort_seen,
  input  wire logic                    target_abort_received,
  input  wire logic                    target_abort_signalled,
  input  wire logic                    perr_driven_on_read,
  input  wire logic                    perr_seen_on_write,
  input  wire bioss_pkg::bioss_addr_t  io_addr,
  output logic                         io_forward_hit,
  output bioss_pkg::bioss_addr_t       io_window_bottom_addr,
  output bioss_pkg::bioss_addr_t       io_window_top_addr,
  output bioss_pkg::bioss_byte_t       secondary_latency_count
);
  import bioss_pkg::*;

  bioss_byte_t  sec_lat_reg;
  logic [3:0]   io_window_bottom_nibble_reg;
  logic [3:0]   io_window_top_nibble_reg;
  logic [15:0]  io_bottom_upper_reg;
  logic [15:0]  io_top_upper_reg;
  logic [15:0]  stat_err_reg;
  logic [15:0]  stat_set;
  logic [15:0]  stat_clr;
  logic [15:0]  stat_view;
  bioss_byte_t  rdata_next;
  logic [3:0]   io_addressing_width_code;
  logic [15:0]  stat_err_next;
  bioss_addr_t  io_window_bottom_next;
  bioss_addr_t  io_window_top_next;

  // Fixed status bits must never be clearable, or a write of ones would wipe them
  if ((`BIOSS_STAT_W1C_MASK & `BIOSS_STAT_FIXED) != 16'h0000) begin : g_stat_mask_check
    $error("Fixed and clearable status bits overlap");
  end

  // The expanded limits must fill the address exactly: upper half, nibble and low bits
  if ($bits(bioss_addr_t) != $bits(`BIOSS_UPPER_RESET) + $bits(`BIOSS_IO_NIBBLE_RESET)
                             + $bits(`BIOSS_IO_LOW_BOTTOM)) begin : g_addr_width_check
    $error("Window address width does not match its pieces");
  end

  assign io_addressing_width_code = `BIOSS_IO_TYPE_CODE; // [R6]

  // Plain storage; the secondary bus logic does the counting
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sec_lat_reg <= `BIOSS_SEC_LAT_RESET; // [R1]
    end else if (cfg_wr && cfg_addr == `BIOSS_OFF_SEC_LAT) begin
      sec_lat_reg <= cfg_wdata; // [R1]
    end
  end

  // Low nibble is never stored, so writes to it cannot land
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      io_window_bottom_nibble_reg <= `BIOSS_IO_NIBBLE_RESET;
      io_window_top_nibble_reg    <= `BIOSS_IO_NIBBLE_RESET;
    end else if (cfg_wr) begin
      if (cfg_addr == `BIOSS_OFF_IO_BOTTOM) begin
        io_window_bottom_nibble_reg <= cfg_wdata[7:4]; // [R2]
      end
      if (cfg_addr == `BIOSS_OFF_IO_TOP) begin
        io_window_top_nibble_reg <= cfg_wdata[7:4]; // [R3]
      end
    end
  end

  // Upper halves are written a byte at a time, low byte at the lower offset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      io_bottom_upper_reg <= `BIOSS_UPPER_RESET;
    end else if (cfg_wr) begin
      if (cfg_addr == `BIOSS_OFF_IO_BOT_UP_LO) begin
        io_bottom_upper_reg[7:0] <= cfg_wdata; // [R4]
      end
      if (cfg_addr == `BIOSS_OFF_IO_BOT_UP_HI) begin
        io_bottom_upper_reg[15:8] <= cfg_wdata; // [R4]
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      io_top_upper_reg <= `BIOSS_UPPER_RESET;
    end else if (cfg_wr) begin
      if (cfg_addr == `BIOSS_OFF_IO_TOP_UP_LO) begin
        io_top_upper_reg[7:0] <= cfg_wdata; // [R5]
      end
      if (cfg_addr == `BIOSS_OFF_IO_TOP_UP_HI) begin
        io_top_upper_reg[15:8] <= cfg_wdata; // [R5]
      end
    end
  end

  // Status events; set wins over a same-cycle clear
  always_comb begin
    stat_set = 16'h0000;
    stat_set[`BIOSS_BIT_PAR] = addr_attr_err_as_target | data_err_as_write_target
                             | data_err_as_read_master; // [R8] [R9]
    stat_set[`BIOSS_BIT_SERR]       = serr_seen; // [R10]
    stat_set[`BIOSS_BIT_MASTER_ABORT_SEEN_FLAG]     = master_abort_seen; // [R11]
    stat_set[`BIOSS_BIT_TARGET_ABORT_RECEIVED_FLAG] = target_abort_received; // [R11]
    stat_set[`BIOSS_BIT_TARGET_ABORT_SIGNALLED_FLAG] = target_abort_signalled; // [R11]
    stat_set[`BIOSS_BIT_MASTER_DATA_PARITY_FLAG]    = parity_response_enable
                                    & (perr_driven_on_read | perr_seen_on_write); // [R12]
  end

  // Write-one-clear strobes, one byte lane at a time
  always_comb begin
    stat_clr = 16'h0000;
    if (cfg_wr && cfg_addr == `BIOSS_OFF_SEC_STAT_LO) begin
      stat_clr[7:0] = cfg_wdata; // [R14]
    end
    if (cfg_wr && cfg_addr == `BIOSS_OFF_SEC_STAT_HI) begin
      stat_clr[15:8] = cfg_wdata; // [R14]
    end
  end

  // Set wins over a same-cycle clear, so an event is never lost to a racing write
  always_comb begin
    stat_err_next = ((stat_err_reg & ~stat_clr) | stat_set) & `BIOSS_STAT_W1C_MASK; // [R14]
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stat_err_reg <= 16'h0000;
    end else begin
      stat_err_reg <= stat_err_next; // [R14]
    end
  end

  // Fixed fields are merged in at read time and never stored
  assign stat_view = stat_err_reg | `BIOSS_STAT_FIXED; // [R13]

  always_comb begin
    unique case (cfg_addr)
      `BIOSS_OFF_SEC_LAT:      rdata_next = sec_lat_reg;
      `BIOSS_OFF_IO_BOTTOM:    rdata_next = {io_window_bottom_nibble_reg, io_addressing_width_code}; // [R6]
      `BIOSS_OFF_IO_TOP:       rdata_next = {io_window_top_nibble_reg, io_addressing_width_code}; // [R6]
      `BIOSS_OFF_SEC_STAT_LO:  rdata_next = stat_view[7:0];
      `BIOSS_OFF_SEC_STAT_HI:  rdata_next = stat_view[15:8];
      `BIOSS_OFF_IO_BOT_UP_LO: rdata_next = io_bottom_upper_reg[7:0];
      `BIOSS_OFF_IO_BOT_UP_HI: rdata_next = io_bottom_upper_reg[15:8];
      `BIOSS_OFF_IO_TOP_UP_LO: rdata_next = io_top_upper_reg[7:0];
      `BIOSS_OFF_IO_TOP_UP_HI: rdata_next = io_top_upper_reg[15:8];
      default:                 rdata_next = 8'h00;
    endcase
  end

  // Read data stand until the next read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_rdata <= 8'h00;
    end else if (cfg_rd) begin
      cfg_rdata <= rdata_next;
    end
  end

  // Expanded window limits, registered so the compare sees stable values
  always_comb begin
    io_window_bottom_next = {io_bottom_upper_reg, io_window_bottom_nibble_reg, `BIOSS_IO_LOW_BOTTOM}; // [R2] [R4]
    io_window_top_next    = {io_top_upper_reg, io_window_top_nibble_reg, `BIOSS_IO_LOW_TOP}; // [R3] [R5]
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      io_window_bottom_addr <= {`BIOSS_UPPER_RESET, `BIOSS_IO_NIBBLE_RESET, `BIOSS_IO_LOW_BOTTOM};
    end else begin
      io_window_bottom_addr <= io_window_bottom_next; // [R2] [R4]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      io_window_top_addr <= {`BIOSS_UPPER_RESET, `BIOSS_IO_NIBBLE_RESET, `BIOSS_IO_LOW_TOP};
    end else begin
      io_window_top_addr <= io_window_top_next; // [R3] [R5]
    end
  end

  // Timer value goes straight out to the secondary bus logic
  assign secondary_latency_count = sec_lat_reg; // [R1]

  // A hit lags a limit write by two edges; the forwarding logic must allow for it
  bioss_window_cmp bioss_window_cmp_inst (
    .bottom (io_window_bottom_addr),
    .top    (io_window_top_addr),
    .addr   (io_addr),
    .hit    (io_forward_hit)
  );
endmodule : bioss_bank

// ===== verilog/bioss_pkg.sv
// Purpose: Types shared by the bridge I/O window and secondary status bank
// Assumes: Nothing
// Notes:   Offsets live in bioss_regs.svh
package bioss_pkg;
  typedef logic [7:0]  bioss_byte_t;
  typedef logic [31:0] bioss_addr_t;
endpackage : bioss_pkg

// ===== verilog/bioss_regs.svh
// Purpose: Offsets, field positions, reset values for the bridge I/O window and secondary status bank
// Assumes: Byte offsets of the type-one configuration header
// Notes:   Definitions only
`ifndef BIOSS_REGS_SVH
`define BIOSS_REGS_SVH
`define BIOSS_OFF_SEC_LAT      8'h1b
`define BIOSS_OFF_IO_BOTTOM    8'h1c
`define BIOSS_OFF_IO_TOP       8'h1d
`define BIOSS_OFF_SEC_STAT_LO  8'h1e
`define BIOSS_OFF_SEC_STAT_HI  8'h1f
`define BIOSS_OFF_IO_BOT_UP_LO 8'h30
`define BIOSS_OFF_IO_BOT_UP_HI 8'h31
`define BIOSS_OFF_IO_TOP_UP_LO 8'h32
`define BIOSS_OFF_IO_TOP_UP_HI 8'h33
`define BIOSS_SEC_LAT_RESET    8'h00
`define BIOSS_IO_NIBBLE_RESET  4'h0
`define BIOSS_IO_TYPE_CODE     4'h1
`define BIOSS_IO_LOW_BOTTOM    12'h000
`define BIOSS_IO_LOW_TOP       12'hfff
`define BIOSS_UPPER_RESET      16'h0000
`define BIOSS_STAT_FIXED       16'h0280
`define BIOSS_STAT_W1C_MASK    16'hf900
`define BIOSS_BIT_PAR          15
`define BIOSS_BIT_SERR         14
`define BIOSS_BIT_MASTER_ABORT_SEEN_FLAG       13
`define BIOSS_BIT_TARGET_ABORT_RECEIVED_FLAG   12
`define BIOSS_BIT_TARGET_ABORT_SIGNALLED_FLAG   11
`define BIOSS_BIT_MASTER_DATA_PARITY_FLAG      8
`endif

// ===== verilog/bioss_window_cmp.sv
// Purpose: I/O forwarding window compare
// Assumes: Limits already expanded to 32-bit addresses
// Notes:   Empty window when bottom exceeds top
`timescale 1ns/1ps
module bioss_window_cmp (
  input  wire bioss_pkg::bioss_addr_t bottom,
  input  wire bioss_pkg::bioss_addr_t top,
  input  wire bioss_pkg::bioss_addr_t addr,
  output logic                        hit
);
  import bioss_pkg::*;
  assign hit = (addr >= bottom) && (addr <= top); // [R7]
endmodule : bioss_window_cmp
